// ### hw/charge_pkg.sv
// Purpose: Shared constants for the charge stage sequencer
// Assumes: 32-bit APB register words, 16-bit measurement codes
// Notes: Thresholds and levels are in raw converter codes
// Overview of operation
// - At start, measure battery voltage and output current and pick the starting stage from them.
// - A fully discharged battery selects the pre-charge stage.
// - Pre-charge drives constant current at the pre-charge current level.
// - Pre-charge moves to bulk once voltage reaches the bulk threshold.
// - Bulk returns to pre-charge below bulk threshold minus voltage hysteresis.
// - Bulk drives constant current at the bulk current level.
// - Bulk holds until voltage reaches absorption threshold, then enters absorption.
// - Absorption switches the power stage to a constant-voltage target.
// - Absorption enters float once output current drops below float threshold minus current hysteresis.
// - Float modulates on time of a constant voltage at float level.
// - Float returns to bulk below the float-to-bulk voltage threshold.
// - Bulk-to-pre, absorption-to-bulk and absorption-to-float apply hysteresis; float-to-bulk uses its own threshold.
// - Supply range fault enabled after reset; out-of-range supply halts charging.
// - Supply back in range re-selects the stage from measurements.
package charge_pkg;

  localparam int unsigned DATA_W = 16;

  // Stage codes, Gray along pre, bulk, absorption, float
  typedef enum logic [2:0] {
    ST_INIT  = 3'h0,
    ST_PRE   = 3'h1,
    ST_BULK  = 3'h3,
    ST_ABS   = 3'h2,
    ST_FLOAT = 3'h6,
    ST_HALT  = 3'h7
  } stage_e;

  // Register word indices (byte address = 4 * index)
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_STATUS = 4'h1;
  localparam logic [3:0] IDX_PRE_I = 4'h2;
  localparam logic [3:0] IDX_BULK_I = 4'h3;
  localparam logic [3:0] IDX_BULK_V = 4'h4;
  localparam logic [3:0] IDX_V_HYST = 4'h5;
  localparam logic [3:0] IDX_ABS_V = 4'h6;
  localparam logic [3:0] IDX_ABS_CV = 4'h7;
  localparam logic [3:0] IDX_FLOAT_I = 4'h8;
  localparam logic [3:0] IDX_I_HYST = 4'h9;
  localparam logic [3:0] IDX_FLOAT_V = 4'ha;
  localparam logic [3:0] IDX_FB_V = 4'hb;
  localparam logic [3:0] IDX_SUP_MIN = 4'hc;
  localparam logic [3:0] IDX_SUP_MAX = 4'hd;
  localparam logic [3:0] IDX_FLT_PER = 4'he;
  localparam logic [3:0] IDX_MEAS = 4'hf;
  localparam logic [7:0] ADDR_TOP = 8'h3f;

  // CTRL fields
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_SUPF_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h3;

  // STATUS fields
  localparam int unsigned STAT_STAGE_LSB = 0;
  localparam int unsigned STAT_HALT_BIT = 4;
  localparam int unsigned STAT_SUPOK_BIT = 5;

  // Reset values of setpoint registers
  localparam logic [15:0] RST_PRE_I = 16'h0100;
  localparam logic [15:0] RST_BULK_I = 16'h0800;
  localparam logic [15:0] RST_BULK_V = 16'h2000;
  localparam logic [15:0] RST_V_HYST = 16'h0080;
  localparam logic [15:0] RST_ABS_V = 16'h3000;
  localparam logic [15:0] RST_ABS_CV = 16'h3000;
  localparam logic [15:0] RST_FLOAT_I = 16'h0100;
  localparam logic [15:0] RST_I_HYST = 16'h0020;
  localparam logic [15:0] RST_FLOAT_V = 16'h2c00;
  localparam logic [15:0] RST_FB_V = 16'h2800;
  localparam logic [15:0] RST_SUP_MIN = 16'h1000;
  localparam logic [15:0] RST_SUP_MAX = 16'hf000;
  localparam logic [15:0] RST_FLT_PER = 16'h0100;

endpackage : charge_pkg

// ### hw/float_mod_if.sv
// Purpose: Link between stage sequencer and float on-time modulator
// Assumes: Same clock on both ends
// Notes: Sequencer drives run, period, level, sample strobe
`timescale 1ns/100ps
interface float_mod_if #(parameter int unsigned W = 16);
  logic run;
  logic sample;
  logic [W-1:0] period;
  logic [W-1:0] level;
  logic [W-1:0] vbat;
  logic gate;
  modport ctrl (output run, output sample, output period, output level, output vbat,
    input gate);
  modport mod (input run, input sample, input period, input level, input vbat,
    output gate);
endinterface : float_mod_if

// ### hw/float_modulator.sv
// Purpose: Float stage on-time modulation of the constant-voltage output
// Assumes: One sample strobe per new battery measurement
// Notes: On time starts at a full period on entry to float
`timescale 1ns/100ps
module float_modulator #(
  parameter int unsigned W = 16
) (
  input wire logic clk,
  input wire logic rst,
  float_mod_if.mod fm
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] on_q;

  always_ff @(posedge clk) begin
    if (rst || !fm.run || cnt_q >= fm.period - W'(1)) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + W'(1);
    end
  end

  // Battery below float level: lengthen on time, else shorten it
  always_ff @(posedge clk) begin
    if (rst || !fm.run) begin
      on_q <= fm.period;
    end else if (fm.sample) begin
      if (fm.vbat < fm.level) begin
        on_q <= (on_q >= fm.period) ? fm.period : on_q + W'(1);
      end else begin
        on_q <= (on_q == '0) ? '0 : on_q - W'(1);
      end
    end
  end

  assign fm.gate = fm.run && (cnt_q < on_q);

endmodule : float_modulator

// ### hw/charge_stage_sequencer.sv
// Purpose: Charge stage selection and power stage command
// Assumes: Converter codes held stable while MEAS_VALID is high
// Notes: APB slave with zero wait states
`timescale 1ns/100ps
module charge_stage_sequencer #(
  parameter int unsigned W = charge_pkg::DATA_W
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic MEAS_VALID,
  input wire logic [W-1:0] BATT_V,
  input wire logic [W-1:0] OUT_I,
  input wire logic [W-1:0] SUPPLY_V,
  output logic [2:0] STAGE,
  output logic CC_MODE,
  output logic CV_MODE,
  output logic [W-1:0] I_TARGET,
  output logic [W-1:0] V_TARGET,
  output logic OUT_EN,
  output logic HALTED
);

  ////////////////////////////////////////////////////////////////////////////
  // Measurement capture

  // Codes come from another domain: two stages each before use
  logic vld_s1_q;
  logic vld_s2_q;
  logic vld_s3_q;
  logic [W-1:0] vb_s1_q;
  logic [W-1:0] vb_s2_q;
  logic [W-1:0] io_s1_q;
  logic [W-1:0] io_s2_q;
  logic [W-1:0] vs_s1_q;
  logic [W-1:0] vs_s2_q;
  logic [W-1:0] vbat_q;
  logic [W-1:0] iout_q;
  logic [W-1:0] vsup_q;
  logic eval_q;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      vld_s1_q <= 1'b0;
      vld_s2_q <= 1'b0;
      vld_s3_q <= 1'b0;
    end else begin
      vld_s1_q <= MEAS_VALID;
      vld_s2_q <= vld_s1_q;
      vld_s3_q <= vld_s2_q;
    end
  end

  always_ff @(posedge CLOCK) begin
    vb_s1_q <= BATT_V;
    vb_s2_q <= vb_s1_q;
    io_s1_q <= OUT_I;
    io_s2_q <= io_s1_q;
    vs_s1_q <= SUPPLY_V;
    vs_s2_q <= vs_s1_q;
  end

  // Latch codes on the rising edge of the valid level
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      vbat_q <= '0;
      iout_q <= '0;
      vsup_q <= '0;
      eval_q <= 1'b0;
    end else begin
      eval_q <= vld_s2_q && !vld_s3_q;
      if (vld_s2_q && !vld_s3_q) begin
        vbat_q <= vb_s2_q;
        iout_q <= io_s2_q;
        vsup_q <= vs_s2_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Setpoint registers

  logic [1:0] ctrl_q;
  logic [W-1:0] pre_i_q;
  logic [W-1:0] bulk_i_q;
  logic [W-1:0] bulk_v_q;
  logic [W-1:0] v_hyst_q;
  logic [W-1:0] abs_v_q;
  logic [W-1:0] abs_cv_q;
  logic [W-1:0] float_i_q;
  logic [W-1:0] i_hyst_q;
  logic [W-1:0] float_v_q;
  logic [W-1:0] fb_v_q;
  logic [W-1:0] sup_min_q;
  logic [W-1:0] sup_max_q;
  logic [W-1:0] flt_per_q;
  logic [3:0] idx;
  logic wr_en;
  logic mapped;
  logic [W-1:0] wd;

  assign idx = PADDR[5:2];
  assign mapped = (PADDR <= charge_pkg::ADDR_TOP) && (PADDR[1:0] == 2'h0);
  assign wr_en = PSEL && PENABLE && PWRITE && mapped;
  assign wd = PWDATA[W-1:0];
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ctrl_q <= charge_pkg::CTRL_RST;
      pre_i_q <= W'(charge_pkg::RST_PRE_I);
      bulk_i_q <= W'(charge_pkg::RST_BULK_I);
      bulk_v_q <= W'(charge_pkg::RST_BULK_V);
      v_hyst_q <= W'(charge_pkg::RST_V_HYST);
      abs_v_q <= W'(charge_pkg::RST_ABS_V);
      abs_cv_q <= W'(charge_pkg::RST_ABS_CV);
      float_i_q <= W'(charge_pkg::RST_FLOAT_I);
      i_hyst_q <= W'(charge_pkg::RST_I_HYST);
      float_v_q <= W'(charge_pkg::RST_FLOAT_V);
      fb_v_q <= W'(charge_pkg::RST_FB_V);
      sup_min_q <= W'(charge_pkg::RST_SUP_MIN);
      sup_max_q <= W'(charge_pkg::RST_SUP_MAX);
      flt_per_q <= W'(charge_pkg::RST_FLT_PER);
    end else if (wr_en) begin
      case (idx)
        charge_pkg::IDX_CTRL: ctrl_q <= PWDATA[1:0];
        charge_pkg::IDX_PRE_I: pre_i_q <= wd;
        charge_pkg::IDX_BULK_I: bulk_i_q <= wd;
        charge_pkg::IDX_BULK_V: bulk_v_q <= wd;
        charge_pkg::IDX_V_HYST: v_hyst_q <= wd;
        charge_pkg::IDX_ABS_V: abs_v_q <= wd;
        charge_pkg::IDX_ABS_CV: abs_cv_q <= wd;
        charge_pkg::IDX_FLOAT_I: float_i_q <= wd;
        charge_pkg::IDX_I_HYST: i_hyst_q <= wd;
        charge_pkg::IDX_FLOAT_V: float_v_q <= wd;
        charge_pkg::IDX_FB_V: fb_v_q <= wd;
        charge_pkg::IDX_SUP_MIN: sup_min_q <= wd;
        charge_pkg::IDX_SUP_MAX: sup_max_q <= wd;
        charge_pkg::IDX_FLT_PER: flt_per_q <= wd;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stage decision

  charge_pkg::stage_e stage_q;
  charge_pkg::stage_e stage_d;
  logic supply_ok_q;
  logic sup_in;
  logic sup_out;
  logic charge_en;
  logic sup_fault_en;

  assign charge_en = ctrl_q[charge_pkg::CTRL_EN_BIT];
  assign sup_fault_en = ctrl_q[charge_pkg::CTRL_SUPF_BIT];

  // Saturating subtract so a large hysteresis cannot wrap
  function automatic logic [W-1:0] sub_sat(input logic [W-1:0] a, input logic [W-1:0] b);
    sub_sat = (a > b) ? a - b : '0;
  endfunction : sub_sat

  // Saturating add for the lower side of a band
  function automatic logic [W-1:0] add_sat(input logic [W-1:0] a, input logic [W-1:0] b);
    logic [W:0] s;
    s = {1'b0, a} + {1'b0, b};
    add_sat = s[W] ? '1 : s[W-1:0];
  endfunction : add_sat

  // Fresh choice of stage from one sample, no history
  function automatic charge_pkg::stage_e pick_stage(input logic [W-1:0] vb,
      input logic [W-1:0] io);
    if (vb < bulk_v_q) begin
      pick_stage = charge_pkg::ST_PRE;
    end else if (vb < abs_v_q) begin
      pick_stage = charge_pkg::ST_BULK;
    end else if (io < float_i_q) begin
      pick_stage = charge_pkg::ST_FLOAT;
    end else begin
      pick_stage = charge_pkg::ST_ABS;
    end
  endfunction : pick_stage

  // Supply band with hysteresis: leaving uses the bare limits,
  // coming back needs the voltage hysteresis margin inside them
  assign sup_out = (vsup_q < sup_min_q) || (vsup_q > sup_max_q);
  assign sup_in = (vsup_q >= add_sat(sup_min_q, v_hyst_q)) &&
    (vsup_q <= sub_sat(sup_max_q, v_hyst_q));

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      supply_ok_q <= 1'b0;
    end else if (eval_q) begin
      if (sup_out) begin
        supply_ok_q <= 1'b0;
      end else if (sup_in) begin
        supply_ok_q <= 1'b1;
      end
    end
  end

  // At most one step per sample, since stage_q only moves on eval_q or, with charge_en low, to ST_INIT
  always_comb begin
    stage_d = stage_q;
    if (!charge_en) begin
      stage_d = charge_pkg::ST_INIT;
    end else if (eval_q) begin
      if (sup_fault_en && sup_out) begin
        stage_d = charge_pkg::ST_HALT;
      end else begin
        case (stage_q)
          charge_pkg::ST_INIT: begin
            stage_d = pick_stage(vbat_q, iout_q);
          end
          charge_pkg::ST_HALT: begin
            if (!sup_fault_en || sup_in) begin
              stage_d = pick_stage(vbat_q, iout_q);
            end
          end
          charge_pkg::ST_PRE: begin
            if (vbat_q >= bulk_v_q) begin
              stage_d = charge_pkg::ST_BULK;
            end
          end
          charge_pkg::ST_BULK: begin
            if (vbat_q < sub_sat(bulk_v_q, v_hyst_q)) begin
              stage_d = charge_pkg::ST_PRE;
            end else if (vbat_q >= abs_v_q) begin
              stage_d = charge_pkg::ST_ABS;
            end
          end
          charge_pkg::ST_ABS: begin
            if (vbat_q < sub_sat(abs_v_q, v_hyst_q)) begin
              stage_d = charge_pkg::ST_BULK;
            end else if (iout_q < sub_sat(float_i_q, i_hyst_q)) begin
              stage_d = charge_pkg::ST_FLOAT;
            end
          end
          charge_pkg::ST_FLOAT: begin
            if (vbat_q < fb_v_q) begin
              stage_d = charge_pkg::ST_BULK;
            end
          end
          default: begin
            stage_d = charge_pkg::ST_INIT;
          end
        endcase
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      stage_q <= charge_pkg::ST_INIT;
    end else begin
      stage_q <= stage_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Float modulation

  float_mod_if #(.W(W)) fm ();

  assign fm.run = (stage_q == charge_pkg::ST_FLOAT);
  assign fm.sample = eval_q;
  assign fm.period = flt_per_q;
  assign fm.level = float_v_q;
  assign fm.vbat = vbat_q;

  float_modulator #(.W(W)) u_float (
    .clk(CLOCK),
    .rst(RST),
    .fm(fm.ctrl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Power stage command

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      CC_MODE <= 1'b0;
      CV_MODE <= 1'b0;
      I_TARGET <= '0;
      V_TARGET <= '0;
      OUT_EN <= 1'b0;
    end else begin
      CC_MODE <= 1'b0;
      CV_MODE <= 1'b0;
      I_TARGET <= '0;
      V_TARGET <= '0;
      OUT_EN <= 1'b0;
      case (stage_q)
        charge_pkg::ST_PRE: begin
          CC_MODE <= 1'b1;
          I_TARGET <= pre_i_q;
          OUT_EN <= 1'b1;
        end
        charge_pkg::ST_BULK: begin
          CC_MODE <= 1'b1;
          I_TARGET <= bulk_i_q;
          OUT_EN <= 1'b1;
        end
        charge_pkg::ST_ABS: begin
          CV_MODE <= 1'b1;
          V_TARGET <= abs_cv_q;
          OUT_EN <= 1'b1;
        end
        charge_pkg::ST_FLOAT: begin
          CV_MODE <= 1'b1;
          V_TARGET <= float_v_q;
          OUT_EN <= fm.gate;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      STAGE <= 3'h0;
      HALTED <= 1'b0;
    end else begin
      STAGE <= stage_q;
      HALTED <= (stage_q == charge_pkg::ST_HALT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, launched in the setup phase

  logic [31:0] rd_d;

  always_comb begin
    rd_d = 32'h0;
    case (idx)
      charge_pkg::IDX_CTRL: rd_d[1:0] = ctrl_q;
      charge_pkg::IDX_STATUS: begin
        rd_d[charge_pkg::STAT_STAGE_LSB +: 3] = stage_q;
        rd_d[charge_pkg::STAT_HALT_BIT] = (stage_q == charge_pkg::ST_HALT);
        rd_d[charge_pkg::STAT_SUPOK_BIT] = supply_ok_q;
      end
      charge_pkg::IDX_PRE_I: rd_d[W-1:0] = pre_i_q;
      charge_pkg::IDX_BULK_I: rd_d[W-1:0] = bulk_i_q;
      charge_pkg::IDX_BULK_V: rd_d[W-1:0] = bulk_v_q;
      charge_pkg::IDX_V_HYST: rd_d[W-1:0] = v_hyst_q;
      charge_pkg::IDX_ABS_V: rd_d[W-1:0] = abs_v_q;
      charge_pkg::IDX_ABS_CV: rd_d[W-1:0] = abs_cv_q;
      charge_pkg::IDX_FLOAT_I: rd_d[W-1:0] = float_i_q;
      charge_pkg::IDX_I_HYST: rd_d[W-1:0] = i_hyst_q;
      charge_pkg::IDX_FLOAT_V: rd_d[W-1:0] = float_v_q;
      charge_pkg::IDX_FB_V: rd_d[W-1:0] = fb_v_q;
      charge_pkg::IDX_SUP_MIN: rd_d[W-1:0] = sup_min_q;
      charge_pkg::IDX_SUP_MAX: rd_d[W-1:0] = sup_max_q;
      charge_pkg::IDX_FLT_PER: rd_d[W-1:0] = flt_per_q;
      charge_pkg::IDX_MEAS: rd_d[W-1:0] = vbat_q;
      default: rd_d = 32'h0;
    endcase
    if (!mapped) begin
      rd_d = 32'h0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      PRDATA <= 32'h0;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= rd_d;
    end
  end

endmodule : charge_stage_sequencer

// ### tb/charge_stage_sequencer_monitor.sv
// Purpose: Port-level checks of the charge stage sequencer
// Assumes: Stage codes 1 pre, 3 bulk, 2 absorption, 6 float, 7 halt
// Notes: Bound from the testbench top file
`timescale 1ns/100ps
module charge_stage_sequencer_monitor #(
  parameter int unsigned W = 16
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [7:0] PADDR,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic MEAS_VALID,
  input wire logic [2:0] STAGE,
  input wire logic CC_MODE,
  input wire logic CV_MODE,
  input wire logic [W-1:0] I_TARGET,
  input wire logic OUT_EN,
  input wire logic HALTED
);
  logic [3:0] since_q;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////////
  // Cycles since the last sample strobe, saturating
  always_ff @(posedge CLOCK) begin
    if (RST) since_q <= 4'hf;
    else if ($rose(MEAS_VALID)) since_q <= 4'h0;
    else if (since_q != 4'hf) since_q <= since_q + 4'h1;
  end
  ////////////////////////////////////////////////////////////////
  pre_cc_cmd_a: assert property (STAGE == 3'h1 |-> CC_MODE && !CV_MODE)
    else $error("pre-charge without constant current");
  bulk_cc_cmd_a: assert property (STAGE == 3'h3 |-> CC_MODE && !CV_MODE)
    else $error("bulk without constant current");
  abs_cv_cmd_a: assert property (STAGE == 3'h2 |-> CV_MODE && !CC_MODE && I_TARGET == '0)
    else $error("absorption without constant voltage");
  float_cv_cmd_a: assert property (STAGE == 3'h6 |-> CV_MODE && !CC_MODE)
    else $error("float without constant voltage");
  halt_quiet_a: assert property (HALTED |-> STAGE == 3'h7 && !OUT_EN && !CC_MODE && !CV_MODE)
    else $error("halt with output active");
  sample_paced_a: assert property ($changed(STAGE) && STAGE != 3'h0 |-> since_q inside {[4'h2:4'h9]})
    else $error("stage changed away from a sample");
  pre_one_step_a: assert property ($past(STAGE) == 3'h1 && STAGE != 3'h1
    |-> STAGE inside {3'h3, 3'h7, 3'h0})
    else $error("pre-charge skipped a stage");
  abs_exit_a: assert property ($past(STAGE) == 3'h2 && STAGE != 3'h2
    |-> STAGE inside {3'h6, 3'h3, 3'h7, 3'h0})
    else $error("bad exit from absorption");
  float_exit_a: assert property ($past(STAGE) == 3'h6 && STAGE != 3'h6
    |-> STAGE inside {3'h3, 3'h7, 3'h0})
    else $error("bad exit from float");
  apb_refuse_a: assert property (PSEL && PENABLE && PADDR > 8'h3f |-> PSLVERR && PREADY)
    else $error("unmapped access not refused");
endmodule : charge_stage_sequencer_monitor

// ### tb/power_stage_model.sv
// Purpose: Power stage with converters, delivers one measurement per request
// Assumes: Codes held from before the strobe until well after it
// Notes: Strobe high 3 cycles, then low at least 8 cycles before the next
`timescale 1ns/100ps
module power_stage_model (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic req,
  input wire logic [15:0] v,
  input wire logic [15:0] i,
  input wire logic [15:0] s,
  output logic MEAS_VALID,
  output logic [15:0] BATT_V,
  output logic [15:0] OUT_I,
  output logic [15:0] SUPPLY_V,
  output logic busy
);
  logic [3:0] n_q;
  assign busy = (n_q != 4'h0);
  always_ff @(posedge CLOCK) begin
    if (RST) n_q <= 4'h0;
    else if (req && n_q == 4'h0) n_q <= 4'h1;
    else if (n_q != 4'h0) n_q <= (n_q == 4'ha) ? 4'h0 : n_q + 4'h1;
  end
  // Codes settle two cycles before the strobe and stay put until the next request
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      {BATT_V, OUT_I, SUPPLY_V} <= '0;
    end else if (req && n_q == 4'h0) begin
      {BATT_V, OUT_I, SUPPLY_V} <= {v, i, s};
    end
  end
  always_ff @(posedge CLOCK) begin
    if (RST) MEAS_VALID <= 1'b0;
    else MEAS_VALID <= (n_q >= 4'h2 && n_q <= 4'h4);
  end
endmodule : power_stage_model

// ### tb/testbench.sv
// Purpose: Self-checking bench for the charge stage sequencer
// Assumes: Setpoints at reset values except pre-charge current and float period
// Notes: Walks the stage profile one sample at a time
`timescale 1ns/100ps
module testbench;
  logic CLOCK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, MEAS_VALID, req, busy, err;
  logic CC_MODE, CV_MODE, OUT_EN, HALTED;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [15:0] BATT_V, OUT_I, SUPPLY_V, I_TARGET, V_TARGET, vreq, ireq, sreq;
  logic [2:0] STAGE;
  int n_fail, tests_run;
  charge_stage_sequencer i_dut (.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .MEAS_VALID(MEAS_VALID), .BATT_V(BATT_V), .OUT_I(OUT_I),
    .SUPPLY_V(SUPPLY_V), .STAGE(STAGE), .CC_MODE(CC_MODE), .CV_MODE(CV_MODE),
    .I_TARGET(I_TARGET), .V_TARGET(V_TARGET), .OUT_EN(OUT_EN), .HALTED(HALTED));
  power_stage_model i_ps (.CLOCK(CLOCK), .RST(RST), .req(req), .v(vreq), .i(ireq), .s(sreq),
    .MEAS_VALID(MEAS_VALID), .BATT_V(BATT_V), .OUT_I(OUT_I), .SUPPLY_V(SUPPLY_V), .busy(busy));
  initial begin
    CLOCK = 1'b0;
    forever #4 CLOCK = ~CLOCK;
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    @(posedge CLOCK);
    while (PREADY !== 1'b1) @(posedge CLOCK);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task automatic meas(input logic [15:0] v, input logic [15:0] i, input logic [15:0] s);
    @(posedge CLOCK);
    vreq <= v;
    ireq <= i;
    sreq <= s;
    req <= 1'b1;
    @(posedge CLOCK);
    req <= 1'b0;
    @(posedge CLOCK);
    while (busy) @(posedge CLOCK);
    // Result lands five edges after the strobe, well inside the quiet tail
    repeat (2) @(posedge CLOCK);
  endtask : meas
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////
  task automatic t_regs;
    apb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h3);
    apb(1'b0, 8'h10, 32'h0);
    check(rd, {16'h0, charge_pkg::RST_BULK_V});
    apb(1'b1, 8'h08, 32'h140);
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h140);
    apb(1'b0, 8'h40, 32'h0);
    check({rd[30:0], err}, 32'h1);
    // Misaligned word must be refused and must not reach the pre-charge register
    apb(1'b1, 8'h0a, 32'h7);
    check(32'(err), 32'h1);
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h140);
  endtask : t_regs
  task automatic t_select;
    meas(16'h0500, 16'h0400, 16'h8000);
    check(32'(STAGE), 32'(charge_pkg::ST_PRE));
    check({15'h0, CC_MODE, I_TARGET}, {15'h0, 1'b1, 16'h0140});
  endtask : t_select
  task automatic t_pre_bulk;
    meas(16'h3000, 16'h0400, 16'h8000);
    check(32'(STAGE), 32'(charge_pkg::ST_BULK));
    check(32'(I_TARGET), 32'(charge_pkg::RST_BULK_I));
    meas(16'h1f80, 16'h0400, 16'h8000);
    check(32'(STAGE), 32'(charge_pkg::ST_BULK));
    meas(16'h1f7f, 16'h0400, 16'h8000);
    check(32'(STAGE), 32'(charge_pkg::ST_PRE));
  endtask : t_pre_bulk
  task automatic t_absorb;
    // Short float period so a few samples can walk the on time to zero
    apb(1'b1, 8'h38, 32'h2);
    meas(16'h2000, 16'h0400, 16'h8000);
    meas(16'h2fff, 16'h0400, 16'h8000);
    check(32'(STAGE), 32'(charge_pkg::ST_BULK));
    meas(16'h3000, 16'h0400, 16'h8000);
    check(32'(STAGE), 32'(charge_pkg::ST_ABS));
    check({CV_MODE, 15'h0, V_TARGET}, {1'b1, 15'h0, charge_pkg::RST_ABS_CV});
    meas(16'h3000, 16'h00e0, 16'h8000);
    check(32'(STAGE), 32'(charge_pkg::ST_ABS));
    meas(16'h3000, 16'h00df, 16'h8000);
    check(32'(STAGE), 32'(charge_pkg::ST_FLOAT));
    check({CV_MODE, 15'h0, V_TARGET}, {1'b1, 15'h0, charge_pkg::RST_FLOAT_V});
    check(32'(OUT_EN), 32'h1);
    meas(16'h3000, 16'h00df, 16'h8000);
    meas(16'h3000, 16'h00df, 16'h8000);
    check(32'({STAGE, OUT_EN}), 32'h0000000c);
  endtask : t_absorb
  task automatic t_float_supply;
    meas(16'h2800, 16'h00df, 16'h8000);
    check(32'(STAGE), 32'(charge_pkg::ST_FLOAT));
    meas(16'h27ff, 16'h00df, 16'h8000);
    check(32'(STAGE), 32'(charge_pkg::ST_BULK));
    meas(16'h2100, 16'h0400, 16'h0fff);
    check({29'h0, HALTED, OUT_EN, CC_MODE}, 32'h4);
    meas(16'h3100, 16'h0400, 16'h8000);
    check(32'(STAGE), 32'(charge_pkg::ST_ABS));
  endtask : t_float_supply
  task automatic t_enable;
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h20);
    check(32'(STAGE), 32'(charge_pkg::ST_INIT));
    // Supply fault disabled: out-of-range supply must not halt
    apb(1'b1, 8'h00, 32'h1);
    meas(16'h0500, 16'h0400, 16'h0fff);
    check(32'(STAGE), 32'(charge_pkg::ST_PRE));
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h1);
    apb(1'b0, 8'h3c, 32'h0);
    check(rd, 32'h0500);
  endtask : t_enable
  ////////////////////////////////////////////////////////////////
  initial begin
    {RST, PSEL, PENABLE, PWRITE, req} = 5'h10;
    {PADDR, PWDATA, vreq, ireq, sreq} = '0;
    n_fail = 0;
    tests_run = 0;
    repeat (2) @(posedge CLOCK);
    RST <= 1'b0;
    t_regs();
    t_select();
    t_pre_bulk();
    t_absorb();
    t_float_supply();
    t_enable();
    tally_and_finish();
  end
  // Whole run is a few hundred cycles
  initial begin
    repeat (5000) @(posedge CLOCK);
    n_fail++;
    tally_and_finish();
  end
endmodule : testbench
bind charge_stage_sequencer charge_stage_sequencer_monitor #(.W(W)) i_mon (.CLOCK(CLOCK),
  .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .MEAS_VALID(MEAS_VALID), .STAGE(STAGE), .CC_MODE(CC_MODE),
  .CV_MODE(CV_MODE), .I_TARGET(I_TARGET), .OUT_EN(OUT_EN), .HALTED(HALTED));
